// File: disk_read_director_sequencer_tb_top.sv
// Self-checking bench for the read director sequencer with a disk model.
`timescale 1ns/1ns
module disk_read_director_sequencer_tb_top;
  import dsq_pkg::*;
  typedef struct packed {
    logic [31:0] dir;
    logic [23:0] bits;
    logic mark;
    logic done;
    logic flt;
  } dsq_row_t;
  localparam logic [31:0] READ_ADDRESS_PATTERN = 32'h0000_0004;
  localparam logic [31:0] ANY = 32'h1 << DSQ_DIR_ANY;
  localparam logic [31:0] HI = 32'h1 << DSQ_DIR_HI;
  localparam logic [31:0] WT = 32'h1 << DSQ_DIR_WAIT;
  localparam logic [31:0] GT = 32'h1 << DSQ_DIR_GATE;
  localparam logic [31:0] INV = 32'h1 << DSQ_DIR_INV;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic sector_mark = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, disk_read_clock, disk_data_in, end_of_cylinder, read_gate, head_advance_pulse;
  logic sector_length_check_en, buffer_load_strobe, data_done, condition_met, fault;
  logic seen_done = 1'b0;
  logic er;
  logic [31:0] rd, g1;
  int fails = 0;
  int n_tests = 0;
  int b0;
  int n_load = 0;
  dsq_row_t rows [6];
  always #50 pclk = ~pclk;
  always @(posedge pclk) if (data_done === 1'b1) seen_done <= 1'b1;
  always @(posedge pclk) if (buffer_load_strobe !== 1'b0) n_load++;
  dsq_read_director_seq uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .disk_read_clock(disk_read_clock), .disk_data_in(disk_data_in), .sector_mark(sector_mark),
    .end_of_cylinder(end_of_cylinder), .read_gate(read_gate), .head_advance_pulse(head_advance_pulse),
    .sector_length_check_en(sector_length_check_en), .buffer_load_strobe(buffer_load_strobe),
    .data_done(data_done), .condition_met(condition_met), .fault(fault));
  dsq_disk_model disk (.head_advance_pulse(head_advance_pulse), .disk_read_clock(disk_read_clock),
    .disk_data_in(disk_data_in), .end_of_cylinder(end_of_cylinder));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      fails++;
      end_sim();
    end
  endtask
  // A wait that must end in an event and runs out of its bound stops the run.
  task automatic wait_ev(input int n, input logic must);
    int k;
    k = 0;
    while (k < n && seen_done !== 1'b1 && fault !== 1'b1) begin
      @(posedge pclk);
      k++;
    end
    if (must && k >= n) begin
      fails++;
      end_sim();
    end
  endtask
  task automatic dir_go(input logic [31:0] d);
    seen_done = 1'b0;
    apb(1'b1, DSQ_OFF_DIR, d, rd, er);
  endtask
  task automatic idle_dir();
    apb(1'b1, DSQ_OFF_STATUS, 32'h0000_0090, rd, er);
    apb(1'b1, DSQ_OFF_DIR, 32'(DSQ_OP_SUPPORT), rd, er);
    repeat (4) @(posedge pclk);
  endtask
  initial begin
    rows[0] = '{READ_ADDRESS_PATTERN | ANY | WT | GT, 24'h000000, 1'b0, 1'b1, 1'b0};
    rows[1] = '{READ_ADDRESS_PATTERN | ANY | WT | INV, 24'h000FFF, 1'b0, 1'b1, 1'b0};
    rows[2] = '{READ_ADDRESS_PATTERN | ANY | WT | HI, 24'hFF33FF, 1'b0, 1'b1, 1'b0};
    rows[3] = '{READ_ADDRESS_PATTERN | ANY | WT | HI, 24'hFFFFFF, 1'b1, 1'b0, 1'b1};
    rows[4] = '{READ_ADDRESS_PATTERN | ANY | WT, 24'hFF00FF, 1'b0, 1'b1, 1'b0};
    rows[5] = '{READ_ADDRESS_PATTERN | HI, 24'h000000, 1'b0, 1'b0, 1'b1};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(32'({read_gate, head_advance_pulse, sector_length_check_en, data_done, condition_met, fault}), 32'h0);
    apb(1'b0, DSQ_OFF_RDLEN, 32'h0, rd, er);
    chk(rd, 32'(DSQ_RDLEN_RST));
    apb(1'b0, 8'h20, 32'h0, rd, er);
    chk({rd[30:0], er}, 32'h0000_0001);
    apb(1'b1, DSQ_OFF_RF, 32'h0000_3300, rd, er);
    apb(1'b1, DSQ_OFF_CTRL, 32'h0000_0001, rd, er);
    apb(1'b1, DSQ_OFF_RDLEN, 32'h0000_0002, rd, er);
    foreach (rows[i]) begin
      idle_dir();
      dir_go(rows[i].dir);
      for (int b = 23; b >= 0; b--) disk.send_bit(rows[i].bits[b]);
      if (rows[i].mark) begin
        @(posedge pclk);
        sector_mark <= 1'b1;
        repeat (3) @(posedge pclk);
        sector_mark <= 1'b0;
      end
      wait_ev(30, rows[i].done | rows[i].flt);
      chk(32'(seen_done), 32'(rows[i].done));
      chk(32'(fault), 32'(rows[i].flt));
      chk(32'(read_gate), 32'(rows[i].dir[DSQ_DIR_GATE]));
      apb(1'b0, DSQ_OFF_STATUS, 32'h0, rd, er);
      chk(32'(rd[DSQ_ST_ABORT]), 32'(rows[i].flt));
    end
    idle_dir();
    disk.eoc_en = 1'b1;
    fork
      begin
        for (int b = 0; b < 300; b++) disk.send_bit(1'b0);
        for (int b = 5; b >= 0; b--) disk.send_bit(b != 3 && b != 2);
        for (int b = 0; b < 96; b++) disk.send_bit(b >= 16);
      end
      begin
        dir_go(READ_ADDRESS_PATTERN | ANY | WT | GT);
        wait_ev(3000, 1'b1);
        // The first sync bit is byte position two, so the count after it is three.
        dir_go(READ_ADDRESS_PATTERN | ANY | INV | (32'h1 << DSQ_DIR_LDBC) | (32'h3 << DSQ_DIR_BC_LSB));
        wait_ev(3000, 1'b1);
        dir_go(READ_ADDRESS_PATTERN | HI);
        wait_ev(200, 1'b1);
        chk(32'(fault), 32'h0);
        dir_go(32'(DSQ_OP_SKIP));
        wait_ev(400, 1'b1);
        chk(32'(n_load), 32'h0);
        b0 = disk.n_bits;
        dir_go(32'(DSQ_OP_CWORD) | HI);
        wait_ev(600, 1'b1);
        chk(32'((disk.n_bits - b0) inside {[24:40]}), 32'h1);
        chk(32'(read_gate), 32'h1);
        repeat (40) @(posedge pclk);
      end
    join
    chk(32'(condition_met), 32'h1);
    chk(32'(disk.n_hap), 32'h2);
    apb(1'b0, DSQ_OFF_STATUS, 32'h0, rd, er);
    chk({30'h0, rd[DSQ_ST_CWERR_HI:DSQ_ST_CWERR_LO]}, 32'h3);
    chk(32'(rd[DSQ_ST_FBM]), 32'h0);
    apb(1'b0, DSQ_OFF_CWGEN, 32'h0, g1, er);
    apb(1'b1, DSQ_OFF_DIR, 32'(DSQ_OP_SUPPORT), rd, er);
    repeat (6) @(posedge pclk);
    chk({30'h0, read_gate, sector_length_check_en}, 32'h0);
    apb(1'b0, DSQ_OFF_STATUS, 32'h0, rd, er);
    chk(32'(rd[DSQ_ST_RIP]), 32'h0);
    apb(1'b0, DSQ_OFF_CWGEN, 32'h0, rd, er);
    chk(rd, g1);
    end_sim();
  end
endmodule

// File: dsq_disk_model.sv
// Behavioural disk unit read channel: serial bits with their own read clock.
`timescale 1ns/1ns
module dsq_disk_model (
  // From the controller.
  input wire logic head_advance_pulse,
  // To the controller.
  output logic disk_read_clock,
  output logic disk_data_in,
  output logic end_of_cylinder
);
  logic eoc_en = 1'b0;
  int n_bits = 0;
  int n_hap = 0;
  assign end_of_cylinder = eoc_en;
  initial begin
    disk_read_clock = 1'b0;
    disk_data_in = 1'b0;
  end
  always @(posedge head_advance_pulse) n_hap++;
  // The clock stands still between bits sent; the line then shows the inverse so a stale bit cannot help.
  task automatic send_bit(input logic b);
    disk_data_in = b;
    #400 disk_read_clock = 1'b1;
    n_bits++;
    #400 disk_read_clock = 1'b0;
    disk_data_in = ~b;
  endtask
endmodule

// File: dsq_pkg.sv
// Constants shared by the disk read director sequencer.
package dsq_pkg;
  // Register byte offsets on the APB.
  localparam logic [7:0] DSQ_OFF_DIR = 8'h00;
  localparam logic [7:0] DSQ_OFF_CTRL = 8'h04;
  localparam logic [7:0] DSQ_OFF_STATUS = 8'h08;
  localparam logic [7:0] DSQ_OFF_RDLEN = 8'h0C;
  localparam logic [7:0] DSQ_OFF_CWGEN = 8'h10;
  localparam logic [7:0] DSQ_OFF_RF = 8'h40;
  localparam logic [7:0] DSQ_OFF_RF_END = 8'h7C;
  // Director word fields, bit n of the director is bit n of the word.
  localparam int DSQ_DIR_OP_LSB = 0;
  localparam int DSQ_DIR_HI = 15;
  localparam int DSQ_DIR_GATE = 16;
  localparam int DSQ_DIR_ANY = 21;
  localparam int DSQ_DIR_LDBC = 22;
  localparam int DSQ_DIR_INV = 23;
  localparam int DSQ_DIR_WAIT = 24;
  localparam int DSQ_DIR_BC_LSB = 25;
  localparam int DSQ_DIR_RF_LSB = 28;
  // Director operation codes in the low three bits.
  localparam logic [2:0] DSQ_OP_READ = 3'h1;
  localparam logic [2:0] DSQ_OP_SKIP = 3'h2;
  localparam logic [2:0] DSQ_OP_CWORD = 3'h3;
  localparam logic [2:0] DSQ_OP_RAP = 3'h4;
  localparam logic [2:0] DSQ_OP_SUPPORT = 3'h5;
  // Status and control bit positions.
  localparam int DSQ_ST_RIP = 0;
  localparam int DSQ_ST_CWERR_LO = 2;
  localparam int DSQ_ST_CWERR_HI = 3;
  localparam int DSQ_ST_ABORT = 4;
  localparam int DSQ_ST_COMP = 5;
  localparam int DSQ_ST_BUSY = 6;
  localparam int DSQ_ST_DONE = 7;
  localparam int DSQ_ST_FBM = 8;
  localparam int DSQ_CTRL_SEL = 0;
  // Counter values.
  localparam logic [15:0] DSQ_BYTE_CW = 16'h0004;
  localparam logic [15:0] DSQ_BYTE_ONE = 16'h0001;
  localparam logic [2:0] DSQ_BIT_THREE = 3'h3;
  localparam logic [2:0] DSQ_BIT_FOUR = 3'h4;
  localparam logic [2:0] DSQ_BIT_LAST = 3'h7;
  localparam logic [3:0] DSQ_BYTE_WAIT = 4'h8;
  localparam logic [15:0] DSQ_RDLEN_RST = 16'h0001;
  // Times and derived cycle counts.
  localparam int DSQ_CLK_NS = 100;
  localparam int DSQ_HAP_NS = 500;
  localparam int DSQ_EOC_NS = 1200;
  localparam logic [3:0] DSQ_HAP_CYC = 4'((DSQ_HAP_NS + DSQ_CLK_NS - 1) / DSQ_CLK_NS);
  localparam logic [3:0] DSQ_EOC_CYC = 4'(DSQ_EOC_NS / DSQ_CLK_NS);
  typedef enum logic [1:0] {
    DSQ_IDLE = 2'b00,
    DSQ_READ = 2'b01,
    DSQ_CWORD = 2'b10,
    DSQ_RAP = 2'b11
  } dsq_state_t;
endpackage

// File: dsq_read_director_seq.sv
// Read side director sequencer: read skip, read checkword and read address pattern.
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ns
module dsq_read_director_seq #(
  parameter logic [31:0] CW_POLY = 32'h04C11DB7
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Disk storage unit, asynchronous to pclk.
  input wire logic disk_read_clock,
  input wire logic disk_data_in,
  input wire logic sector_mark,
  input wire logic end_of_cylinder,
  // Drive and controller outputs.
  output logic read_gate,
  output logic head_advance_pulse,
  output logic sector_length_check_en,
  output logic buffer_load_strobe,
  output logic data_done,
  output logic condition_met,
  output logic fault
);
  import dsq_pkg::*;

  function automatic logic [31:0] crc_step(input logic [31:0] g, input logic b);
    crc_step = {g[30:0], 1'b0} ^ ((g[31] ^ b) ? CW_POLY : 32'h00000000);
  endfunction

  logic [3:0] s1_q, s2_q, s3_q, clean_q;
  logic rclk_ev, mark_ev, din_c, eoc_c;
  dsq_state_t state_q;
  logic [31:0] dir_q, gen_q;
  logic [15:0] byte_q, rdlen_q;
  logic [15:0] rf_q [16];
  logic [2:0] bit_q;
  logic [7:0] shreg_q, shnext, pattern;
  logic [3:0] wait_q, hap_cnt_q, eoc_cnt_q;
  logic ctrl_sel_q, skip_q, rip_q, shift_en_q, cw_en_q, fbm_q, hold15_q;
  logic cw_err_q, abort_q, done_st_q, hap_req_q, eoc_seen_q, second_q;
  logic sclk, hit, wr, rd_setup, dir_wr, sts_w1c, mapped;

  // Three stage synchronisers; a change counts only once stages two and three agree.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 4'h0;
      s2_q <= 4'h0;
      s3_q <= 4'h0;
      clean_q <= 4'h0;
    end else begin
      s1_q <= {end_of_cylinder, sector_mark, disk_data_in, disk_read_clock};
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < 4; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          clean_q[i] <= s3_q[i];
        end
      end
    end
  end

  assign rclk_ev = (s2_q[0] == s3_q[0]) && s3_q[0] && !clean_q[0];
  assign mark_ev = (s2_q[2] == s3_q[2]) && s3_q[2] && !clean_q[2];
  assign din_c = clean_q[1];
  assign eoc_c = clean_q[3];
  assign sclk = rclk_ev && shift_en_q;
  assign shnext = {shreg_q[6:0], din_c};
  assign pattern = dir_q[DSQ_DIR_HI] ? rf_q[dir_q[DSQ_DIR_RF_LSB +: 4]][15:8]
                                     : rf_q[dir_q[DSQ_DIR_RF_LSB +: 4]][7:0];
  assign hit = (shnext == pattern) ^ dir_q[DSQ_DIR_INV];

  // APB decode.
  assign wr = psel && penable && pready && pwrite;
  assign rd_setup = psel && !penable;
  assign dir_wr = wr && (paddr == DSQ_OFF_DIR) && (state_q == DSQ_IDLE) && !abort_q;
  assign sts_w1c = wr && (paddr == DSQ_OFF_STATUS);
  assign mapped = (paddr[1:0] == 2'b00) && (paddr <= DSQ_OFF_CWGEN
                  || (paddr >= DSQ_OFF_RF && paddr <= DSQ_OFF_RF_END));

  // The slave answers in the access cycle, so no wait states are ever inserted.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= rd_setup;
      pslverr <= rd_setup && !mapped;
      if (rd_setup) begin
        prdata <= 32'h00000000;
        case (paddr)
          DSQ_OFF_DIR: prdata <= dir_q;
          DSQ_OFF_CTRL: prdata <= {31'h00000000, ctrl_sel_q};
          DSQ_OFF_STATUS: begin
            prdata[DSQ_ST_RIP] <= rip_q;
            prdata[DSQ_ST_CWERR_LO] <= cw_err_q;
            prdata[DSQ_ST_CWERR_HI] <= cw_err_q;
            prdata[DSQ_ST_ABORT] <= abort_q;
            prdata[DSQ_ST_COMP] <= cw_err_q || abort_q;
            prdata[DSQ_ST_BUSY] <= state_q != DSQ_IDLE;
            prdata[DSQ_ST_DONE] <= done_st_q;
            prdata[DSQ_ST_FBM] <= fbm_q;
          end
          DSQ_OFF_RDLEN: prdata <= {16'h0000, rdlen_q};
          DSQ_OFF_CWGEN: prdata <= gen_q;
          default: begin
            if (mapped) begin
              prdata <= {16'h0000, rf_q[paddr[5:2]]};
            end
          end
        endcase
      end
    end
  end

  // Software written configuration and the pattern register file.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_sel_q <= 1'b0;
      rdlen_q <= DSQ_RDLEN_RST;
      for (int i = 0; i < 16; i++) begin
        rf_q[i] <= 16'h0000;
      end
    end else if (wr) begin
      if (paddr == DSQ_OFF_CTRL) begin
        ctrl_sel_q <= pwdata[DSQ_CTRL_SEL];
      end
      if (paddr == DSQ_OFF_RDLEN) begin
        rdlen_q <= pwdata[15:0];
      end
      if (paddr >= DSQ_OFF_RF && paddr <= DSQ_OFF_RF_END) begin
        rf_q[paddr[5:2]] <= pwdata[15:0];
      end
    end
  end

  // Director sequencer. The bit counter and shift register run whenever shift clocks
  // are enabled, so a following director picks up the data stream in step.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= DSQ_IDLE;
      dir_q <= 32'h00000000;
      gen_q <= 32'h00000000;
      byte_q <= 16'h0000;
      bit_q <= 3'h0;
      shreg_q <= 8'h00;
      wait_q <= 4'h0;
      skip_q <= 1'b0;
      rip_q <= 1'b0;
      shift_en_q <= 1'b0;
      cw_en_q <= 1'b0;
      fbm_q <= 1'b0;
      hold15_q <= 1'b0;
      cw_err_q <= 1'b0;
      abort_q <= 1'b0;
      done_st_q <= 1'b0;
      hap_req_q <= 1'b0;
      read_gate <= 1'b0;
      sector_length_check_en <= 1'b0;
      buffer_load_strobe <= 1'b0;
      data_done <= 1'b0;
    end else begin
      data_done <= 1'b0;
      buffer_load_strobe <= 1'b0;
      hap_req_q <= 1'b0;
      // Clears come first so that a same-cycle set below wins.
      if (sts_w1c && pwdata[DSQ_ST_ABORT]) begin
        abort_q <= 1'b0;
      end
      if (sts_w1c && pwdata[DSQ_ST_DONE]) begin
        done_st_q <= 1'b0;
      end
      if (sclk) begin
        shreg_q <= shnext;
        bit_q <= bit_q + 3'h1;
        if (cw_en_q) begin
          gen_q <= crc_step(gen_q, din_c);
        end
      end
      case (state_q)
        DSQ_IDLE: begin
          if (dir_wr) begin
            dir_q <= pwdata;
            case (pwdata[DSQ_DIR_OP_LSB +: 3])
              DSQ_OP_READ, DSQ_OP_SKIP: begin
                skip_q <= pwdata[DSQ_DIR_OP_LSB +: 3] == DSQ_OP_SKIP;
                byte_q <= rdlen_q;
                rip_q <= 1'b1;
                shift_en_q <= 1'b1;
                read_gate <= 1'b1;
                sector_length_check_en <= 1'b1;
                cw_en_q <= 1'b1;
                fbm_q <= 1'b1;
                state_q <= DSQ_READ;
              end
              DSQ_OP_CWORD: begin
                byte_q <= DSQ_BYTE_CW;
                hold15_q <= pwdata[DSQ_DIR_HI];
                rip_q <= 1'b1;
                sector_length_check_en <= 1'b1;
                cw_en_q <= 1'b1;
                state_q <= DSQ_CWORD;
              end
              DSQ_OP_RAP: begin
                gen_q <= 32'h00000000;
                cw_en_q <= 1'b0;
                rip_q <= 1'b1;
                shift_en_q <= 1'b1;
                fbm_q <= 1'b1;
                sector_length_check_en <= 1'b1;
                if (pwdata[DSQ_DIR_GATE]) begin
                  read_gate <= 1'b1;
                end
                wait_q <= pwdata[DSQ_DIR_WAIT] ? DSQ_BYTE_WAIT : 4'h0;
                state_q <= DSQ_RAP;
              end
              DSQ_OP_SUPPORT: begin
                rip_q <= 1'b0;
                sector_length_check_en <= 1'b0;
                read_gate <= 1'b0;
                shift_en_q <= 1'b0;
                cw_en_q <= 1'b0;
                data_done <= 1'b1;
                done_st_q <= 1'b1;
              end
              default: begin
                data_done <= 1'b1;
                done_st_q <= 1'b1;
              end
            endcase
          end
        end
        DSQ_READ: begin
          if (sclk && bit_q == DSQ_BIT_LAST && !skip_q) begin
            buffer_load_strobe <= 1'b1;
          end
          if (sclk && bit_q == DSQ_BIT_FOUR) begin
            if (byte_q == DSQ_BYTE_ONE) begin
              data_done <= 1'b1;
              done_st_q <= 1'b1;
              state_q <= DSQ_IDLE;
            end else begin
              byte_q <= byte_q - 16'h0001;
            end
          end
        end
        DSQ_CWORD: begin
          if (sclk && byte_q == DSQ_BYTE_ONE && bit_q == DSQ_BIT_THREE) begin
            cw_en_q <= 1'b0;
          end
          if (sclk && bit_q == DSQ_BIT_FOUR) begin
            if (byte_q == DSQ_BYTE_ONE) begin
              cw_err_q <= |gen_q;
              hap_req_q <= hold15_q && ctrl_sel_q;
              fbm_q <= 1'b0;
              data_done <= 1'b1;
              done_st_q <= 1'b1;
              state_q <= DSQ_IDLE;
            end else begin
              byte_q <= byte_q - 16'h0001;
            end
          end
        end
        DSQ_RAP: begin
          if (mark_ev) begin
            abort_q <= 1'b1;
            cw_en_q <= 1'b0;
            state_q <= DSQ_IDLE;
          end else if (sclk) begin
            if (wait_q != 4'h0) begin
              wait_q <= wait_q - 4'h1;
            end else if (dir_q[DSQ_DIR_ANY]) begin
              // Zeros and first nonzero bit are both found by the anyplace compare.
              if (hit) begin
                bit_q <= dir_q[DSQ_DIR_LDBC] ? dir_q[DSQ_DIR_BC_LSB +: 3] : 3'h0;
                data_done <= 1'b1;
                done_st_q <= 1'b1;
                state_q <= DSQ_IDLE;
              end
            end else if (bit_q == DSQ_BIT_LAST) begin
              // Sync byte must be there at this byte boundary or the search failed.
              if (hit) begin
                cw_en_q <= 1'b1;
                data_done <= 1'b1;
                done_st_q <= 1'b1;
              end else begin
                abort_q <= 1'b1;
                cw_en_q <= 1'b0;
              end
              state_q <= DSQ_IDLE;
            end
          end
        end
        default: state_q <= DSQ_IDLE;
      endcase
    end
  end

  // Head advance pulse and end of cylinder check; a second pulse is given at most once.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      head_advance_pulse <= 1'b0;
      hap_cnt_q <= 4'h0;
      eoc_cnt_q <= 4'h0;
      eoc_seen_q <= 1'b0;
      second_q <= 1'b0;
    end else if (hap_req_q && hap_cnt_q == 4'h0 && eoc_cnt_q == 4'h0) begin
      head_advance_pulse <= 1'b1;
      hap_cnt_q <= DSQ_HAP_CYC;
      second_q <= 1'b0;
    end else if (hap_cnt_q != 4'h0) begin
      hap_cnt_q <= hap_cnt_q - 4'h1;
      if (hap_cnt_q == 4'h1) begin
        head_advance_pulse <= 1'b0;
        eoc_cnt_q <= second_q ? 4'h0 : DSQ_EOC_CYC;
        eoc_seen_q <= 1'b0;
      end
    end else if (eoc_cnt_q != 4'h0) begin
      eoc_cnt_q <= eoc_cnt_q - 4'h1;
      if (eoc_c) begin
        eoc_seen_q <= 1'b1;
      end
      if (eoc_cnt_q == 4'h1 && (eoc_seen_q || eoc_c)) begin
        head_advance_pulse <= 1'b1;
        hap_cnt_q <= DSQ_HAP_CYC;
        second_q <= 1'b1;
      end
    end
  end

  // Branch condition and fault follow the latched flags with one register stage.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      condition_met <= 1'b0;
      fault <= 1'b0;
    end else begin
      condition_met <= cw_err_q;
      fault <= abort_q;
    end
  end
endmodule

// File: dsq_seq_sva.sv
// Port checker for the read director sequencer, bound to its top module.
`timescale 1ns/1ns
module dsq_seq_sva
  import dsq_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB requests and ready.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  // Disk and drive side.
  input wire logic sector_mark,
  input wire logic read_gate,
  input wire logic head_advance_pulse,
  input wire logic buffer_load_strobe,
  input wire logic data_done,
  input wire logic condition_met,
  input wire logic fault
);
  logic [31:0] dir_q;
  logic sel_q;
  logic acc;
  assign acc = psel && penable && pready && pwrite;
  // Only completed writes move the shadow copies, so a setup cycle alone never counts.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_q <= 32'h0000_0000;
      sel_q <= 1'b0;
    end else if (acc && paddr == DSQ_OFF_DIR) begin
      dir_q <= pwdata;
    end else if (acc && paddr == DSQ_OFF_CTRL) begin
      sel_q <= pwdata[DSQ_CTRL_SEL];
    end
  end
  default clocking dsq_cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  skip_no_load_a: assert property (dir_q[2:0] == DSQ_OP_SKIP |-> !buffer_load_strobe)
    else $error("buffer strobe during read skip");
  hap_cause_a: assert property ($rose(head_advance_pulse) |-> dir_q[2:0] == DSQ_OP_CWORD && dir_q[DSQ_DIR_HI] && sel_q)
    else $error("head advance without its cause");
  hap_width_a: assert property ($rose(head_advance_pulse) |-> head_advance_pulse [*5] ##1 !head_advance_pulse)
    else $error("head advance width wrong");
  hap_gap_a: assert property ($fell(head_advance_pulse) |-> !head_advance_pulse [*8])
    else $error("second head advance too soon");
  done_pulse_a: assert property (data_done |=> !data_done)
    else $error("data done longer than one cycle");
  gate_hold_a: assert property ($fell(read_gate) |-> dir_q[2:0] == DSQ_OP_SUPPORT)
    else $error("read gate dropped early");
  mark_abort_a: assert property ($rose(sector_mark) && dir_q[2:0] == DSQ_OP_RAP && !fault |-> ##[1:10] fault)
    else $error("sector mark did not abort");
  err_branch_a: assert property ($rose(condition_met) |-> data_done || $past(data_done) || $past(data_done, 2))
    else $error("condition met without completion");
endmodule
bind dsq_read_director_seq dsq_seq_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .sector_mark(sector_mark),
  .read_gate(read_gate), .head_advance_pulse(head_advance_pulse), .buffer_load_strobe(buffer_load_strobe),
  .data_done(data_done), .condition_met(condition_met), .fault(fault));
